// *** logic/cms_pkg.sv ***
// Package: register map, field layout and encodings of the CRC engine with memory scan
`default_nettype none
package cms_pkg;
    // ==================================================
    // Register byte offsets
    localparam logic [7:0] CMS_OFF_CTRL = 8'h00;
    localparam logic [7:0] CMS_OFF_LEN = 8'h04;
    localparam logic [7:0] CMS_OFF_DATH = 8'h08;
    localparam logic [7:0] CMS_OFF_DATL = 8'h0C;
    localparam logic [7:0] CMS_OFF_ACCH = 8'h10;
    localparam logic [7:0] CMS_OFF_SCAN_CTRL = 8'h14;
    localparam logic [7:0] CMS_OFF_SCAN_ADDR = 8'h18;
    localparam logic [7:0] CMS_OFF_SCAN_END = 8'h1C;
    localparam logic [7:0] CMS_OFF_POLY = 8'h20;
    // ==================================================
    // Primary control fields
    localparam int CMS_CTRL_EN = 7;
    localparam int CMS_CTRL_GO = 6;
    localparam int CMS_CTRL_BUSY = 5;
    localparam int CMS_CTRL_ZERO_AUGMENT_SELECT = 4;
    localparam int CMS_CTRL_SHIFT = 1;
    localparam int CMS_CTRL_FULL = 0;
    // Scanner control fields
    localparam int CMS_SCAN_EN = 7;
    localparam int CMS_SCAN_RUN = 6;
    localparam int CMS_SCAN_BUSY = 5;
    // ==================================================
    // Reset values
    localparam logic [7:0] CMS_CTRL_RST = 8'h00;
    localparam logic [7:0] CMS_LEN_RST = 8'h00;
    localparam logic [15:0] CMS_ACC_RST = 16'h0000;
    localparam logic [15:0] CMS_ADDR_RST = 16'h0000;
    // Scanner modes
    localparam logic [1:0] CMS_MODE_CONC = 2'h0;
    localparam logic [1:0] CMS_MODE_BURST = 2'h1;
    localparam logic [1:0] CMS_MODE_PEEK = 2'h2;
    localparam logic [1:0] CMS_MODE_TRIG = 2'h3;
    // AHB encodings
    localparam logic [2:0] CMS_HSIZE_WORD = 3'h2;
    // Scanner sequencer states
    typedef enum logic [2:0] {
        CMS_SC_IDLE = 3'b001,
        CMS_SC_WAIT = 3'b010,
        CMS_SC_READ = 3'b100
    } cms_scan_state_t;
endpackage
`default_nettype wire

// *** logic/cms_crc_scan.sv ***
// CRC engine with program memory scanner and AHB-Lite register slave
//
// Summary of operation
// - Watchdog keeps counting; scanner never stalls or clears it.
// - Scanner freezes in debug halt; its registers stay readable.
// - Halt during a scan cycle: delayed instruction may or may not execute.
// - Halt just before a scan cycle: scan and instruction wait for exit.
// - Burst: halt on scan-go write enters debug first; access in flight finishes.
// - Burst: halt mid-burst suspends it; resumes at same address on exit.
// - Peek: idle cycle of a breakpointed instruction is not used.
// - Concurrent/triggered: pending scan completes before PC-breakpoint debug entry.
// - Concurrent/triggered: scan requested in a data-breakpoint cycle is postponed.
// - Single step: ready scan reads flash before debug re-entry.
// - Scan that would stall a software breakpoint completes, then debug entry.
// - Burst: PC breakpoint or step on scan-go enters debug before burst.
// - Burst: software breakpoint on scan-go enters debug; burst runs after exit.
// - CRC enable clear holds shifter and full flag in reset, accumulator keeps its value; set releases it.
// - CRC start bit runs the serial shifter; clearing stops it.
// - Busy reads 1 while shifting in progress or pending, else 0.
// - Accumulator mode 1 augments data with zeros; 0 does not.
// - Direction 1 shifts right LSB first, 0 left MSB first; bits 3-2 zero.
// - Full reads 1 while data word not yet taken into shifter.
// - Length upper nibble is data length minus one, lower polynomial minus one.
// - Low data byte write loads word and sets full; high byte gives upper bits.
// - Accumulator high byte write updates, read returns, upper accumulator bits.
// - Scanner mode 00 concurrent, 01 burst, 10 peek, 11 triggered.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`default_nettype none
module cms_crc_scan
    import cms_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic flash_rd_o,
    output logic [15:0] flash_addr_o,
    input wire logic [15:0] flash_rdata_i,
    input wire logic core_idle_i,
    input wire logic scan_trigger_i,
    input wire logic dbg_halt_i,
    input wire logic dbg_active_i,
    input wire logic pc_bp_hit_i,
    input wire logic data_bp_hit_i,
    input wire logic sw_bp_hit_i,
    input wire logic single_step_i,
    output logic cpu_stall_o,
    output logic dbg_entry_hold_o
);

    // ==================================================
    // Helpers
    // Mask of the low n+1 bits
    function automatic logic [15:0] len_mask(input logic [3:0] n);
        len_mask = 16'hFFFF >> (4'hF - n);
    endfunction
    // One accumulator step for one data bit
    function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic [15:0] poly,
                                             input logic [3:0] poly_len_minus_one, input logic din,
                                             input logic right, input logic aug);
        logic top, fb;
        logic [15:0] sh;
        top = right ? acc[0] : acc[poly_len_minus_one];
        sh = right ? {1'b0, acc[15:1]} : {acc[14:0], 1'b0};
        // Augmented bit enters the window; otherwise it folds into the feedback
        fb = aug ? top : (top ^ din);
        sh = aug ? (sh | (right ? ({15'h0000, din} << poly_len_minus_one) : {15'h0000, din})) : sh;
        crc_step = (sh ^ (fb ? poly : 16'h0000)) & len_mask(poly_len_minus_one);
    endfunction

    // ==================================================
    // Register state
    logic [7:0] ctrl_ff, len_ff;
    logic [15:0] data_ff, acc_ff, poly_ff, shreg_ff, scan_addr_ff, scan_end_ff, flash_addr_ff;
    logic full_ff, scan_en_ff, scan_run_ff, trig_prev_ff, trig_seen_ff, flash_rd_ff, cpu_stall_ff, dbg_hold_ff;
    logic [4:0] shcnt_ff;
    logic [1:0] scan_mode_ff;
    cms_scan_state_t scan_state_ff, nxt_scan_state;
    // Bus slave state
    logic wr_pend_ff, rd_wait_ff, hready_ff;
    logic [7:0] wr_addr_ff, rd_addr_ff;
    logic [31:0] hrdata_ff;

    // ==================================================
    // AHB-Lite decode
    logic acc_phase, wr_ctrl, wr_len, wr_dath, wr_datl, wr_acch;
    logic wr_scan_ctrl, wr_scan_addr, wr_scan_end, wr_poly;
    // Only whole-word accesses are taken; others complete OKAY with no effect
    assign acc_phase = hsel_i && htrans_i[1] && hready_i && (hsize_i == CMS_HSIZE_WORD);
    assign wr_ctrl = wr_pend_ff && (wr_addr_ff == CMS_OFF_CTRL);
    assign wr_len = wr_pend_ff && (wr_addr_ff == CMS_OFF_LEN);
    assign wr_dath = wr_pend_ff && (wr_addr_ff == CMS_OFF_DATH);
    assign wr_datl = wr_pend_ff && (wr_addr_ff == CMS_OFF_DATL);
    assign wr_acch = wr_pend_ff && (wr_addr_ff == CMS_OFF_ACCH);
    assign wr_scan_ctrl = wr_pend_ff && (wr_addr_ff == CMS_OFF_SCAN_CTRL);
    assign wr_scan_addr = wr_pend_ff && (wr_addr_ff == CMS_OFF_SCAN_ADDR);
    assign wr_scan_end = wr_pend_ff && (wr_addr_ff == CMS_OFF_SCAN_END);
    assign wr_poly = wr_pend_ff && (wr_addr_ff == CMS_OFF_POLY);
    // Address phase capture; reads take one wait state so a write just before is seen
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_wait_ff <= 1'b0;
            rd_addr_ff <= 8'h00;
            hready_ff <= 1'b1;
        end else begin
            wr_pend_ff <= acc_phase && hwrite_i;
            rd_wait_ff <= acc_phase && !hwrite_i;
            hready_ff <= !(acc_phase && !hwrite_i);
            if (acc_phase) begin
                wr_addr_ff <= (|haddr_i[31:8]) ? 8'hFF : haddr_i[7:0];
                rd_addr_ff <= (|haddr_i[31:8]) ? 8'hFF : haddr_i[7:0];
            end
        end
    end
    // Read mux; unmapped offsets read zero
    logic [31:0] rd_mux;
    logic crc_busy, scan_busy;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (rd_addr_ff)
            CMS_OFF_CTRL: rd_mux = {24'h000000, ctrl_ff[CMS_CTRL_EN], ctrl_ff[CMS_CTRL_GO], crc_busy,
                                    ctrl_ff[CMS_CTRL_ZERO_AUGMENT_SELECT], 2'b00, ctrl_ff[CMS_CTRL_SHIFT], full_ff};
            CMS_OFF_LEN: rd_mux = {24'h000000, len_ff};
            CMS_OFF_DATH: rd_mux = {24'h000000, data_ff[15:8]};
            CMS_OFF_DATL: rd_mux = {24'h000000, data_ff[7:0]};
            CMS_OFF_ACCH: rd_mux = {24'h000000, acc_ff[15:8]};
            // scanner state stays visible while halted
            CMS_OFF_SCAN_CTRL: rd_mux = {24'h000000, scan_en_ff, scan_run_ff, scan_busy, 3'b000, scan_mode_ff};
            CMS_OFF_SCAN_ADDR: rd_mux = {16'h0000, scan_addr_ff};
            CMS_OFF_SCAN_END: rd_mux = {16'h0000, scan_end_ff};
            CMS_OFF_POLY: rd_mux = {16'h0000, poly_ff};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // Read data registered in the wait cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_wait_ff) begin
            hrdata_ff <= rd_mux;
        end
    end
    assign hrdata_o = hrdata_ff;
    assign hreadyout_o = hready_ff;
    assign hresp_o = 1'b0;

    // ==================================================
    // CRC configuration
    logic crc_en, crc_go;
    logic [3:0] data_len_minus_one, poly_len_minus_one;
    assign crc_en = ctrl_ff[CMS_CTRL_EN];
    assign crc_go = ctrl_ff[CMS_CTRL_GO];
    assign data_len_minus_one = len_ff[7:4];
    assign poly_len_minus_one = len_ff[3:0];

    // Control and length registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= CMS_CTRL_RST;
            len_ff <= CMS_LEN_RST;
            poly_ff <= CMS_ACC_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= {hwdata_i[7:6], 1'b0, hwdata_i[4], 2'b00, hwdata_i[1], 1'b0};
            end
            if (wr_len) begin
                len_ff <= hwdata_i[7:0];
            end
            if (wr_poly) begin
                poly_ff <= hwdata_i[15:0];
            end
        end
    end

    // ==================================================
    // Data path holding register
    logic scan_load, shift_load;
    assign scan_load = flash_rd_ff;
    assign shift_load = crc_en && crc_go && full_ff && (shcnt_ff == 5'h00);
    // Data word from bus or scanner; a new word sets full over the take
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_ff <= 16'h0000;
            full_ff <= 1'b0;
        end else begin
            if (scan_load) begin
                data_ff <= flash_rdata_i;
            end else begin
                // high byte gives upper input bits
                if (wr_dath) begin
                    data_ff[15:8] <= hwdata_i[7:0];
                end
                if (wr_datl) begin
                    data_ff[7:0] <= hwdata_i[7:0];
                end
            end
            if (!crc_en) begin
                full_ff <= 1'b0;
            // low byte write fills the path
            end else if (wr_datl || scan_load) begin
                full_ff <= 1'b1;
            // full drops once the shifter takes the word
            end else if (shift_load) begin
                full_ff <= 1'b0;
            end
        end
    end

    // ==================================================
    // Serial shifter and accumulator
    logic right, din;
    assign right = ctrl_ff[CMS_CTRL_SHIFT];
    assign din = right ? shreg_ff[0] : shreg_ff[data_len_minus_one];
    // One bit per cycle while the start bit is set
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shreg_ff <= 16'h0000;
            shcnt_ff <= 5'h00;
            acc_ff <= CMS_ACC_RST;
        end else begin
            // enable clear holds the shifter in reset
            if (!crc_en) begin
                shreg_ff <= 16'h0000;
                shcnt_ff <= 5'h00;
            end else if (shift_load) begin
                shreg_ff <= data_ff;
                shcnt_ff <= {1'b0, data_len_minus_one} + 5'h01;
            end else if (crc_go && (shcnt_ff != 5'h00)) begin
                shreg_ff <= right ? {1'b0, shreg_ff[15:1]} : {shreg_ff[14:0], 1'b0};
                shcnt_ff <= shcnt_ff - 5'h01;
            end
            // software write of upper accumulator bits
            if (wr_acch) begin
                acc_ff[15:8] <= hwdata_i[7:0];
            end else if (crc_en && crc_go && !shift_load && (shcnt_ff != 5'h00)) begin
                acc_ff <= crc_step(acc_ff, poly_ff, poly_len_minus_one, din, right, ctrl_ff[CMS_CTRL_ZERO_AUGMENT_SELECT]);
            end
        end
    end
    // busy while a word waits or bits remain
    assign crc_busy = full_ff || (shcnt_ff != 5'h00);

    // ==================================================
    // Scanner control registers
    logic scan_last;
    assign scan_last = flash_rd_ff && (flash_addr_ff == scan_end_ff);
    // Software sets run; hardware clears it after the last word
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            scan_en_ff <= 1'b0;
            scan_run_ff <= 1'b0;
            scan_mode_ff <= CMS_MODE_CONC;
            scan_end_ff <= CMS_ADDR_RST;
        end else begin
            if (wr_scan_ctrl) begin
                scan_en_ff <= hwdata_i[CMS_SCAN_EN];
                scan_mode_ff <= hwdata_i[1:0];
            end
            if (wr_scan_ctrl && hwdata_i[CMS_SCAN_RUN]) begin
                scan_run_ff <= 1'b1;
            end else if (scan_last || (wr_scan_ctrl && !hwdata_i[CMS_SCAN_RUN])) begin
                scan_run_ff <= 1'b0;
            end
            if (wr_scan_end) begin
                scan_end_ff <= hwdata_i[15:0];
            end
        end
    end
    // Current address; writes ignored while running
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            scan_addr_ff <= CMS_ADDR_RST;
        end else if (wr_scan_addr && !scan_run_ff) begin
            scan_addr_ff <= hwdata_i[15:0];
        // address advances only on a finished fetch, so a suspended burst resumes in place
        end else if (flash_rd_ff) begin
            scan_addr_ff <= scan_addr_ff + 16'h0001;
        end
    end

    // ==================================================
    // Scan issue decision
    logic is_burst, is_peek, is_trig, mode_ok, block, issue;
    assign is_burst = (scan_mode_ff == CMS_MODE_BURST);
    assign is_peek = (scan_mode_ff == CMS_MODE_PEEK);
    assign is_trig = (scan_mode_ff == CMS_MODE_TRIG);
    // Peek waits for a dead cycle, triggered for a trigger edge
    assign mode_ok = is_peek ? core_idle_i : (is_trig ? trig_seen_ff : 1'b1);
    // Conditions that defer a new access until debug exit
    // halt in the cycle before a scan pushes it past exit
    // halt on the scan-go cycle enters debug before the burst
    // peek never uses the idle cycle of a breakpointed instruction
    // data breakpoint postpones a same-cycle request
    // burst defers to PC breakpoint or step
    // burst defers to a software breakpoint
    assign block = dbg_halt_i || data_bp_hit_i || (is_peek && pc_bp_hit_i)
                   || (is_burst && (pc_bp_hit_i || single_step_i || sw_bp_hit_i));
    // concurrent requests still go ahead on PC breakpoint, step or software breakpoint
    assign issue = (scan_state_ff == CMS_SC_WAIT) && scan_run_ff && !full_ff && crc_en
                   && !dbg_active_i && mode_ok && !block;
    // Sequencer next state
    always_comb begin
        nxt_scan_state = scan_state_ff;
        unique case (scan_state_ff)
            CMS_SC_IDLE: begin
                if (scan_run_ff) begin
                    nxt_scan_state = CMS_SC_WAIT;
                end
            end
            CMS_SC_WAIT: begin
                if (!scan_run_ff) begin
                    nxt_scan_state = CMS_SC_IDLE;
                end else if (issue) begin
                    nxt_scan_state = CMS_SC_READ;
                end
            end
            // an access in flight always completes, even under a halt
            CMS_SC_READ: nxt_scan_state = scan_last ? CMS_SC_IDLE : CMS_SC_WAIT;
            default: nxt_scan_state = CMS_SC_IDLE;
        endcase
    end
    // Sequencer; scanner disable resets its internal state only
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            scan_state_ff <= CMS_SC_IDLE;
            flash_rd_ff <= 1'b0;
            flash_addr_ff <= CMS_ADDR_RST;
        end else if (!scan_en_ff) begin
            scan_state_ff <= CMS_SC_IDLE;
            flash_rd_ff <= 1'b0;
        end else begin
            scan_state_ff <= nxt_scan_state;
            flash_rd_ff <= issue;
            if (issue) begin
                flash_addr_ff <= scan_addr_ff;
            end
        end
    end
    // Trigger edge catch; a new edge wins over consumption
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            trig_prev_ff <= 1'b0;
            trig_seen_ff <= 1'b0;
        end else begin
            trig_prev_ff <= scan_trigger_i;
            if (!scan_en_ff) begin
                trig_seen_ff <= 1'b0;
            end else if (scan_trigger_i && !trig_prev_ff) begin
                trig_seen_ff <= 1'b1;
            end else if (issue && is_trig) begin
                trig_seen_ff <= 1'b0;
            end
        end
    end

    assign scan_busy = flash_rd_ff || (scan_state_ff == CMS_SC_WAIT && scan_run_ff && !full_ff);

    // ==================================================
    // Core and debug handshake
    // stall only holds the core; the watchdog has no path from here
    // core decides whether the delayed instruction runs before entry
    // debug entry held while a scan cycle is in flight
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_stall_ff <= 1'b0;
            dbg_hold_ff <= 1'b0;
        end else begin
            cpu_stall_ff <= scan_en_ff && ((is_burst && scan_run_ff && !scan_last) || (issue && !is_peek));
            dbg_hold_ff <= scan_en_ff && issue;
        end
    end
    assign flash_rd_o = flash_rd_ff;
    assign flash_addr_o = flash_addr_ff;
    assign cpu_stall_o = cpu_stall_ff;
    assign dbg_entry_hold_o = dbg_hold_ff;

endmodule
`default_nettype wire

// *** bench/cms_crc_scan_properties.sv ***
// Checker: bus timing and scanner hold-off properties
`default_nettype none
module cms_crc_scan_chk (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic flash_rd_o,
    input wire logic dbg_halt_i,
    input wire logic dbg_active_i,
    input wire logic data_bp_hit_i,
    input wire logic dbg_entry_hold_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Shared clock and reset
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Accepted address phase
    sequence s_take;
        hsel_i && htrans_i[1] && hready_i && hsize_i == 3'h2;
    endsequence
    sequence s_rd_done;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    AST_READ_WAIT: assert property (s_take ##0 !hwrite_i |=> s_rd_done)
        else $error("read wait is not one cycle");
    AST_WRITE_NOWAIT: assert property (s_take ##0 hwrite_i |=> hreadyout_o)
        else $error("write was stretched");
    AST_RESP_OKAY: assert property (hresp_o == 1'b0)
        else $error("error response seen");
    AST_RDATA_UPPER: assert property (!hreadyout_o |=> hrdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_FLASH_GAP: assert property (flash_rd_o |=> !flash_rd_o)
        else $error("flash reads back to back");
    AST_DBG_FREEZE: assert property (dbg_active_i |=> !flash_rd_o)
        else $error("scanner read while in debug");
    AST_HALT_DEFER: assert property (dbg_halt_i |=> !flash_rd_o)
        else $error("scan issued under halt");
    AST_DBP_DEFER: assert property (data_bp_hit_i |=> !flash_rd_o)
        else $error("scan issued on data breakpoint");
    AST_ENTRY_HOLD: assert property (flash_rd_o |-> dbg_entry_hold_o)
        else $error("debug entry not held during scan");
endmodule
bind cms_crc_scan cms_crc_scan_chk i_cms_crc_scan_chk (.clk_sys_i, .rst_i, .hsel_i, .htrans_i, .hwrite_i,
    .hsize_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .flash_rd_o, .dbg_halt_i, .dbg_active_i,
    .data_bp_hit_i, .dbg_entry_hold_o);
`default_nettype wire

// *** bench/cms_flash_model.sv ***
// Program flash model answering scanner reads
`default_nettype none
module cms_flash_model (
    input wire logic clk_sys_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_ff = 16'h0000;
    // Word valid only under the strobe; inverted junk otherwise
    assign rdata_o = rd_i ? {addr_i[7:0] ^ 8'h5A, ~addr_i[15:8]} : ~last_ff;
    // Remember last word so idle data differs from it
    always_ff @(posedge clk_sys_i) if (rd_i) last_ff <= rdata_o;
endmodule
`default_nettype wire

// *** bench/test_cms_crc_scan.sv ***
// Self-checking bench: registers, CRC arithmetic and scanner
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module test_cms_crc_scan
    import cms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] POLY = 16'h1021;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = CMS_HSIZE_WORD;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, flash_rd_o, cpu_stall_o, dbg_entry_hold_o;
    logic [15:0] flash_addr_o, flash_rdata_i;
    logic [7:0] ev = 8'h00;
    logic noise = 1'b0;
    int num_checks = 0;
    int n_fail = 0;
    int nrd = 0;
    int nst = 0;
    int cyc = 0;
    cms_crc_scan i_cms_crc_scan (.clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .flash_rd_o, .flash_addr_o,
        .flash_rdata_i, .core_idle_i(ev[0]), .scan_trigger_i(ev[1]), .dbg_halt_i(ev[2]),
        .dbg_active_i(ev[3]), .pc_bp_hit_i(ev[4]), .data_bp_hit_i(ev[5]), .sw_bp_hit_i(ev[6]),
        .single_step_i(ev[7]), .cpu_stall_o, .dbg_entry_hold_o);
    cms_flash_model i_cms_flash_model (.clk_sys_i, .rd_i(flash_rd_o), .addr_i(flash_addr_o),
        .rdata_o(flash_rdata_i));
    // ====
    // Clock, core/debug noise, read counter, hang guard
    initial forever #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (noise) ev <= {$urandom % 8 == 0, $urandom % 8 == 0, $urandom % 8 == 0,
        $urandom % 8 == 0, $urandom % 8 == 0, $urandom % 8 == 0, 2'($urandom)};
    // Flash reads, and those the core was not stalled for
    always @(posedge clk_sys_i) if (flash_rd_o === 1'b1) begin
        nrd <= nrd + 1;
        nst <= nst + (cpu_stall_o !== 1'b1);
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // Verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One AHB single transfer; ready sampled before this edge's updates
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr_i <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        hsel_i <= 1'b1;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic drain();
        logic [31:0] q;
        do xfer(1'b0, CMS_OFF_CTRL, 32'h0, q); while (q[CMS_CTRL_BUSY] === 1'b1);
    endtask
    // Reference CRC over one 16-bit word, 16-bit polynomial
    function automatic logic [15:0] crc_word(logic [15:0] acc, logic [15:0] w, logic aug, logic rt);
        logic d, fb;
        for (int i = 0; i < 16; i++) begin
            d = rt ? w[i] : w[15 - i];
            fb = (rt ? acc[0] : acc[15]) ^ (d & !aug);
            acc = rt ? {d & aug, acc[15:1]} : {acc[14:0], d & aug};
            if (fb) acc = acc ^ POLY;
        end
        return acc;
    endfunction
    function automatic logic [15:0] fw(logic [15:0] a);
        return {a[7:0] ^ 8'h5A, ~a[15:8]};
    endfunction
    // ====
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] acc, w;
        void'($urandom(32'hFD7FB9C9));
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rchk(CMS_OFF_CTRL, {24'h0, CMS_CTRL_RST});
        rchk(CMS_OFF_LEN, 32'h0);
        rchk(CMS_OFF_ACCH, 32'h0);
        wr(8'hFC, 32'hFF);
        rchk(8'hFC, 32'h0);
        w = 16'($urandom);
        wr(CMS_OFF_LEN, {24'h0, w[7:0]});
        rchk(CMS_OFF_LEN, {24'h0, w[7:0]});
        wr(CMS_OFF_ACCH, {24'h0, w[15:8]});
        rchk(CMS_OFF_ACCH, {24'h0, w[15:8]});
        wr(CMS_OFF_LEN, 32'hFF);
        wr(CMS_OFF_ACCH, 32'h0);
        wr(CMS_OFF_POLY, {16'h0, POLY});
        // Start clear keeps the word; enable clear drops it
        wr(CMS_OFF_CTRL, 32'h9E);
        wr(CMS_OFF_DATL, 32'h5A);
        rchk(CMS_OFF_CTRL, 32'hB3);
        wr(CMS_OFF_CTRL, 32'h0);
        rchk(CMS_OFF_CTRL, 32'h0);
        acc = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            wr(CMS_OFF_CTRL, {24'h0, 2'h3, 1'h0, k[0], 2'h0, k[1], 1'h0});
            repeat (3) begin
                w = 16'($urandom);
                wr(CMS_OFF_DATH, {24'h0, w[15:8]});
                wr(CMS_OFF_DATL, {24'h0, w[7:0]});
                rchk(CMS_OFF_CTRL, {24'h0, 3'h7, k[0], 2'h0, k[1], 1'h0});
                drain();
                acc = crc_word(acc, w, k[0], k[1]);
                rchk(CMS_OFF_ACCH, {24'h0, acc[15:8]});
            end
        end
        // Scanner in every mode under random halts and breakpoints
        noise = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(CMS_OFF_SCAN_ADDR, 32'h10);
            wr(CMS_OFF_SCAN_END, 32'h13);
            nrd = 0;
            nst = 0;
            wr(CMS_OFF_SCAN_CTRL, {24'h0, 2'h3, 4'h0, k[1:0]});
            do xfer(1'b0, CMS_OFF_SCAN_CTRL, 32'h0, r); while (r[CMS_SCAN_RUN] === 1'b1);
            `CHK(nrd, 4)
            `CHK(nst, (k == 2) ? 4 : 0)
            rchk(CMS_OFF_SCAN_ADDR, 32'h14);
            for (int a = 16; a < 20; a++) acc = crc_word(acc, fw(16'(a)), 1'b1, 1'b1);
            drain();
            rchk(CMS_OFF_ACCH, {24'h0, acc[15:8]});
        end
        close_out();
    end
endmodule
`default_nettype wire
